// *** design/asr_pkg.sv ***
package asr_pkg;
  // ----------------------------------------------------------------
  // register map (word addresses on the Avalon slave)
  // ----------------------------------------------------------------
  localparam logic [1:0] ADDR_SEL      = 2'h0;
  localparam logic [1:0] ADDR_RES_LOW  = 2'h1;
  localparam logic [1:0] ADDR_RES_HIGH = 2'h2;
  localparam logic [1:0] ADDR_STATUS   = 2'h3;
  // ----------------------------------------------------------------
  // field positions and reset values
  // ----------------------------------------------------------------
  localparam int         REF_HI        = 7;
  localparam int         REF_LO        = 6;
  localparam int         ALIGN_BIT     = 5;
  localparam int         CHAN_HI       = 4;
  localparam int         DONE_BIT      = 0;
  localparam int         BUSY_BIT      = 1;
  localparam int         RES_W         = 10;
  localparam logic [7:0] SEL_RESET     = 8'h00;
  // ----------------------------------------------------------------
  // reference select encodings and result limits
  // ----------------------------------------------------------------
  localparam logic [1:0] REF_EXT_PIN   = 2'h0;
  localparam logic [1:0] REF_SUPPLY    = 2'h1;
  localparam logic [1:0] REF_RESERVED  = 2'h2;
  localparam logic [1:0] REF_INTERNAL  = 2'h3;
  localparam logic [9:0] SE_MIN        = 10'h000;
  localparam logic [9:0] SE_MAX        = 10'h3FF;
  localparam logic [9:0] DIFF_MIN      = 10'h200;
  localparam logic [9:0] DIFF_MAX      = 10'h1FF;
  // ----------------------------------------------------------------
  // channel table boundaries (channel_gain_select codes)
  // ----------------------------------------------------------------
  localparam logic [4:0] CH_DIFF_FIRST = 5'h08;
  localparam logic [4:0] CH_DIFF_LAST  = 5'h1D;
  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int         SYS_CLK_HZ    = 40_000_000;
  localparam int         CONV_CLK_HZ   = 5_000_000;
  localparam int         CONV_DIV      = SYS_CLK_HZ / CONV_CLK_HZ;
  localparam int         CONV_CYCLES   = 13;
endpackage : asr_pkg

// *** design/asr_clk_div.sv ***
`timescale 1ns/1ps
// one-cycle enable pulse every DIV system clocks
module asr_clk_div
  import asr_pkg::*;
#(
  parameter int DIV = CONV_DIV
) (
  input  wire logic sys_clk_in,  // system clock
  input  wire logic rst_in,      // synchronous reset, active high
  output logic      tick_out     // one-cycle converter clock enable
);
  typedef struct packed {
    logic [7:0] cnt;
    logic       tick;
  } asr_div_st_t;

  asr_div_st_t st;
  asr_div_st_t next_st;

  always_comb begin
    next_st      = st;
    next_st.tick = 1'b0;
    if (st.cnt == 8'(DIV - 1)) begin
      next_st.cnt  = 8'h00;
      next_st.tick = 1'b1;
    end else begin
      next_st.cnt = st.cnt + 8'h01;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign tick_out = st.tick;
endmodule : asr_clk_div

// *** design/asr_format.sv ***
`timescale 1ns/1ps
// places a 10-bit result into the two result bytes
module asr_format
  import asr_pkg::*;
(
  input  wire logic [9:0] result_in,  // raw conversion code
  input  wire logic       left_in,    // result_left_align
  output logic      [7:0] low_out,    // result_low_byte view
  output logic      [7:0] high_out    // result_high_byte view
);
  always_comb begin
    if (left_in) begin
      high_out = result_in[9:2];
      low_out  = {result_in[1:0], 6'h00};
    end else begin
      high_out = {6'h00, result_in[9:8]};
      low_out  = result_in[7:0];
    end
  end
endmodule : asr_format

// *** design/asr_top.sv ***
// Local design decisions: the Avalon-MM register port and the register addresses.
`timescale 1ns/1ps
// Operation
// - result bytes hold the finished conversion once done flag is high
// - single-ended result is unsigned, 0x000 at ground to 0x3FF at reference-1
// - differential result is two's complement 0x200 (-512) to 0x1FF (+511)
// - top result bit in the high byte gives differential polarity, one negative
// - differential saturates at 0x1FF; one step below zero reads 0x3FF
// - reference select rewritten mid-conversion applies only after done
// - reference 00 external pin, 01 analog supply, 10 reserved, 11 internal
// - bit 5 picks left alignment when one, right alignment when zero
// - alignment change re-maps result bytes at once, even mid-conversion
// - same input may be chosen as both differential inputs
// - channel and gain select rewritten mid-conversion applies only after done
// - done flag sets when a conversion ends and results are updated
module asr_top
  import asr_pkg::*;
#(
  parameter int DIV     = CONV_DIV,
  parameter int CYCLES  = CONV_CYCLES
) (
  input  wire logic        sys_clk_in,          // 40 MHz system clock
  input  wire logic        rst_in,              // synchronous reset, active high
  // Avalon-MM slave
  input  wire logic [1:0]  avs_address_in,      // word address
  input  wire logic        avs_read_in,         // read request
  input  wire logic        avs_write_in,        // write request
  input  wire logic [31:0] avs_writedata_in,    // write data
  output logic      [31:0] avs_readdata_out,    // read data
  output logic             avs_waitrequest_out, // stall
  // analog front end
  input  wire logic        conv_start_in,       // start a conversion (pulse)
  input  wire logic        sample_diff_in,      // core reports a differential pair
  input  wire logic signed [11:0] sample_in,    // raw core value, may exceed range
  output logic      [1:0]  reference_select_out,     // applied reference
  output logic      [4:0]  channel_gain_select_out,  // applied channel/gain
  output logic             internal_ref_on_out,      // internal reference enabled
  output logic             conv_busy_out,            // conversion in progress
  output logic             conversion_done_flag_out  // conversion complete
);
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ASR_IDLE,
    ASR_CONV
  } asr_phase_t;

  typedef struct packed {
    asr_phase_t  phase;
    logic [7:0]  input_selection;
    logic [1:0]  ref_applied;
    logic [4:0]  chan_applied;
    logic [4:0]  conv_cnt;
    logic [9:0]  result;
    logic        done;
    logic        ack;
    logic [31:0] rdata;
    logic [7:0]  res_low;
    logic [7:0]  res_high;
    logic        busy;
    logic        int_ref;
    logic        bus_wait;
  } asr_st_t;

  asr_st_t st;
  asr_st_t next_st;
  logic    tick;
  logic [7:0] fmt_low;
  logic [7:0] fmt_high;
  logic [9:0] coded;
  logic       req;
  logic       wr_sel;
  logic       last_tick;
  logic       clr_done;
  logic [7:0] wdata_byte;

  asr_clk_div #(
    .DIV (DIV)
  ) u_div (
    .sys_clk_in (sys_clk_in),
    .rst_in     (rst_in),
    .tick_out   (tick)
  );

  // alignment is taken live from the register, so a change re-maps at once
  asr_format u_fmt (
    .result_in (next_st.result),
    .left_in   (next_st.input_selection[ALIGN_BIT]),
    .low_out   (fmt_low),
    .high_out  (fmt_high)
  );

  // ----------------------------------------------------------------
  // result coding
  // ----------------------------------------------------------------
  always_comb begin
    if (sample_diff_in) begin
      if (sample_in > 12'sd511) begin
        coded = DIFF_MAX;
      end else if (sample_in < -12'sd512) begin
        coded = DIFF_MIN;
      end else begin
        coded = sample_in[9:0];
      end
    end else begin
      if (sample_in < 12'sd0) begin
        coded = SE_MIN;
      end else if (sample_in > 12'sd1023) begin
        coded = SE_MAX;
      end else begin
        coded = sample_in[9:0];
      end
    end
  end

  assign req       = avs_read_in | avs_write_in;
  // writes land at the edge where waitrequest is seen low, the same edge the master uses
  assign wr_sel    = avs_write_in && st.ack && avs_address_in == ADDR_SEL;
  assign clr_done  = avs_write_in && st.ack && avs_address_in == ADDR_STATUS
                     && avs_writedata_in[DONE_BIT];
  assign wdata_byte = avs_writedata_in[7:0];
  assign last_tick = st.phase == ASR_CONV && tick && st.conv_cnt == 5'(CYCLES - 1);

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    next_st     = st;
    next_st.ack = req && !st.ack;
    if (wr_sel) begin
      next_st.input_selection = avs_writedata_in[7:0];
    end
    // a set of the done flag wins over a software clear in the same cycle
    if (clr_done) begin
      next_st.done = 1'b0;
    end
    unique case (st.phase)
      ASR_IDLE: begin
        // selections follow the register while idle
        next_st.ref_applied  = next_st.input_selection[REF_HI:REF_LO];
        next_st.chan_applied = next_st.input_selection[CHAN_HI:0];
        if (conv_start_in) begin
          next_st.phase    = ASR_CONV;
          next_st.conv_cnt = 5'h00;
        end
      end
      ASR_CONV: begin
        if (tick) begin
          next_st.conv_cnt = st.conv_cnt + 5'h01;
        end
        if (last_tick) begin
          next_st.phase        = ASR_IDLE;
          next_st.result       = coded;
          next_st.done         = 1'b1;
          // deferred selections take effect with the done flag
          next_st.ref_applied  = next_st.input_selection[REF_HI:REF_LO];
          next_st.chan_applied = next_st.input_selection[CHAN_HI:0];
        end
      end
    endcase
    next_st.busy     = next_st.phase == ASR_CONV;
    next_st.int_ref  = next_st.ref_applied == REF_INTERNAL;
    next_st.bus_wait = !next_st.ack;
    next_st.res_low  = fmt_low;
    next_st.res_high = fmt_high;
    next_st.rdata    = 32'h0000_0000;
    if (avs_read_in && !st.ack) begin
      unique case (avs_address_in)
        ADDR_SEL:      next_st.rdata = {24'h0, next_st.input_selection};
        ADDR_RES_LOW:  next_st.rdata = {24'h0, fmt_low};
        ADDR_RES_HIGH: next_st.rdata = {24'h0, fmt_high};
        ADDR_STATUS:   next_st.rdata = {30'h0, next_st.phase == ASR_CONV, next_st.done};
      endcase
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      st          <= '0;
      // stall stays up out of reset so a first request is never answered early
      st.bus_wait <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign avs_readdata_out         = st.rdata;
  assign avs_waitrequest_out      = st.bus_wait;
  assign reference_select_out     = st.ref_applied;
  assign channel_gain_select_out  = st.chan_applied;
  assign conv_busy_out            = st.busy;
  assign conversion_done_flag_out = st.done;
  // reserved reference code leaves the internal reference off
  assign internal_ref_on_out      = st.int_ref;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  sequence s_conv_end;
    st.phase == ASR_CONV ##1 st.phase == ASR_IDLE;
  endsequence

  a_done_after_conv: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    s_conv_end |-> st.done)
    else $error("done flag not set at conversion end");

  a_result_latched: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    last_tick |=> st.result == $past(coded))
    else $error("result not latched at conversion end");

  a_ref_held: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    (st.phase == ASR_CONV && !last_tick) |=> $stable(st.ref_applied))
    else $error("reference changed during conversion");

  a_chan_held: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    (st.phase == ASR_CONV && !last_tick) |=> $stable(st.chan_applied))
    else $error("channel changed during conversion");

  a_sel_applied: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    last_tick |=> st.ref_applied == st.input_selection[REF_HI:REF_LO])
    else $error("deferred reference not applied");

  a_diff_sat: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    (sample_diff_in && sample_in > 12'sd511) |-> coded == DIFF_MAX)
    else $error("differential saturation wrong");

  a_diff_sign: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    (sample_diff_in && sample_in < 12'sd0) |-> coded[9])
    else $error("negative result lacks sign bit");

  a_se_range: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    (!sample_diff_in && sample_in > 12'sd1023) |-> coded == SE_MAX)
    else $error("single-ended clamp wrong");

  a_align_live: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    (wr_sel && avs_writedata_in[ALIGN_BIT]) |=> st.res_high == st.result[9:2])
    else $error("alignment change not immediate");

  a_right_align: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    !st.input_selection[ALIGN_BIT] |-> st.res_high[7:2] == 6'h00)
    else $error("right-aligned high byte not clear");

  a_bus_answer: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    (req && avs_waitrequest_out) |=> (!req || !avs_waitrequest_out))
    else $error("bus answer late");

  // ----------------------------------------------------------------
  // bus, conversion and coding checks
  // ----------------------------------------------------------------
  sequence s_bus_first;
    req && !st.ack;
  endsequence

  sequence s_conv_start;
    st.phase == ASR_IDLE && conv_start_in;
  endsequence

  a_wait_first: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    s_bus_first |=> !avs_waitrequest_out)
    else $error("waitrequest not lowered in answer cycle");

  a_wait_idle: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    !req |=> avs_waitrequest_out)
    else $error("waitrequest low without a request");

  a_rdata_idle: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    !(avs_read_in && !st.ack) |=> avs_readdata_out == 32'h0000_0000)
    else $error("read data not cleared outside answer");

  a_rdata_upper: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    avs_readdata_out[31:8] == 24'h00_0000)
    else $error("read data upper bits not zero");

  a_sel_written: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    wr_sel |=> st.input_selection == $past(wdata_byte))
    else $error("selection write lost");

  a_sel_readback: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    (s_bus_first and avs_read_in && avs_address_in == ADDR_SEL)
      |=> avs_readdata_out[7:0] == st.input_selection)
    else $error("selection read back wrong");

  a_start_busy: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    s_conv_start |=> conv_busy_out)
    else $error("conversion start not taken");

  a_busy_mirror: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    conv_busy_out == (st.phase == ASR_CONV))
    else $error("busy output disagrees with phase");

  a_cnt_bound: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    st.phase == ASR_CONV |-> st.conv_cnt < 5'(CYCLES))
    else $error("conversion ran past its length");

  a_done_rise: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    $rose(st.done) |-> $past(last_tick))
    else $error("done flag set outside conversion end");

  a_done_clear: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    (clr_done && !last_tick) |=> !st.done)
    else $error("done flag not cleared by software");

  a_done_wins: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    (clr_done && last_tick) |=> st.done)
    else $error("clear beat a same-cycle done set");

  a_result_hold: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    !last_tick |=> $stable(st.result))
    else $error("result changed outside conversion end");

  a_ref_follow: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    st.phase == ASR_IDLE |=> st.ref_applied == st.input_selection[REF_HI:REF_LO])
    else $error("reference not following register while idle");

  a_chan_follow: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    st.phase == ASR_IDLE |=> st.chan_applied == st.input_selection[CHAN_HI:0])
    else $error("channel not following register while idle");

  a_chan_applied: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    last_tick |=> st.chan_applied == st.input_selection[CHAN_HI:0])
    else $error("deferred channel not applied");

  a_iref_decode: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    internal_ref_on_out == (reference_select_out == REF_INTERNAL))
    else $error("internal reference enable wrong");

  a_left_high: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    st.input_selection[ALIGN_BIT] |-> st.res_high == st.result[9:2])
    else $error("left-aligned high byte wrong");

  a_left_low: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    st.input_selection[ALIGN_BIT] |-> st.res_low[5:0] == 6'h00)
    else $error("left-aligned low byte not padded");

  a_right_low: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    !st.input_selection[ALIGN_BIT] |-> st.res_low == st.result[7:0])
    else $error("right-aligned low byte wrong");

  a_diff_minus: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    (sample_diff_in && sample_in == -12'sd1) |-> coded == 10'h3FF)
    else $error("one step below zero not coded as minus one");

  a_diff_floor: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    (sample_diff_in && sample_in < -12'sd512) |-> coded == DIFF_MIN)
    else $error("differential floor wrong");

  a_se_floor: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    (!sample_diff_in && sample_in < 12'sd0) |-> coded == SE_MIN)
    else $error("single-ended floor wrong");

  a_diff_pos: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    (sample_diff_in && sample_in >= 12'sd0) |-> !coded[9])
    else $error("positive result carries sign bit");
endmodule : asr_top

// *** verification/asr_afe_model.sv ***
`timescale 1ns/1ps
// ------------------------------------------------------------
// front end stand-in
// ------------------------------------------------------------
module asr_afe_model
  import asr_pkg::*;
(
  input  wire logic               clk_in,     // system clock
  input  wire logic               rst_in,     // synchronous reset
  input  wire logic               go_in,      // bench asks for a conversion
  input  wire logic        [11:0] value_in,   // raw value to present
  input  wire logic               busy_in,    // conversion in progress
  input  wire logic        [4:0]  chan_in,    // applied channel/gain
  output logic                    start_out,  // start pulse
  output logic                    diff_out,   // differential coding
  output logic signed      [11:0] sample_out  // raw sample
);
  logic        armed;
  logic        busy_q;
  logic [11:0] held;
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      start_out <= 1'b0;
      armed     <= 1'b0;
      busy_q    <= 1'b0;
      held      <= 12'h000;
    end else begin
      start_out <= go_in && !busy_in;
      busy_q    <= busy_in;
      if (go_in) begin
        held  <= value_in;
        armed <= 1'b1;
      end else if (busy_q && !busy_in) begin
        armed <= 1'b0;
      end
    end
  end
  // outside a conversion the line shows the inverse, so a late sample cannot pass
  assign sample_out = armed ? held : ~held;
  // codes 08..1D are pairs; 08 puts one input on both sides
  assign diff_out = (chan_in >= CH_DIFF_FIRST) && (chan_in <= CH_DIFF_LAST);
endmodule : asr_afe_model

// *** verification/adc_select_and_result_format_test.sv ***
`timescale 1ns/1ps
module adc_select_and_result_format_test;
  import asr_pkg::*;
  logic               clk, rst, rd, wr, go, busy, done, iref, start, diff, wreq;
  logic        [1:0]  addr, refsel;
  logic        [4:0]  chan;
  logic        [31:0] wdata, rdata, q;
  logic        [11:0] val;
  logic signed [11:0] sample;
  int                 n_mismatch = 0;
  int                 n_checks = 0;

  asr_top #(.DIV(2), .CYCLES(CONV_CYCLES)) dut (.sys_clk_in(clk), .rst_in(rst),
    .avs_address_in(addr), .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wdata),
    .avs_readdata_out(rdata), .avs_waitrequest_out(wreq), .conv_start_in(start),
    .sample_diff_in(diff), .sample_in(sample), .reference_select_out(refsel),
    .channel_gain_select_out(chan), .internal_ref_on_out(iref), .conv_busy_out(busy),
    .conversion_done_flag_out(done));
  asr_afe_model afe (.clk_in(clk), .rst_in(rst), .go_in(go), .value_in(val),
    .busy_in(busy), .chan_in(chan), .start_out(start), .diff_out(diff), .sample_out(sample));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task end_of_test;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : end_of_test

  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      n_mismatch++;
    end
  endtask : chk

  // ------------------------------------------------------------
  // bus and conversion helpers
  // ------------------------------------------------------------
  // waitrequest and readdata are taken at the rising edge, before that edge's updates land
  task automatic bus(input logic w, input logic [1:0] a, input logic [7:0] d);
    int   n;
    logic wt;
    addr  <= a;
    wdata <= {24'h0, d};
    wr    <= w;
    rd    <= !w;
    n = 0;
    do begin
      @(posedge clk);
      wt = wreq;
      q  = rdata;
      n++;
    end while (wt !== 1'b0 && n < 20);
    wr <= 1'b0;
    rd <= 1'b0;
    @(posedge clk);
    if (wt !== 1'b0) begin
      n_mismatch++;
      end_of_test();
    end
  endtask : bus

  task rdchk(input logic [1:0] a, input logic [7:0] exp);
    bus(1'b0, a, 8'h00);
    chk(q, {24'h0, exp});
  endtask : rdchk

  task kick(input logic [11:0] v);
    bus(1'b1, ADDR_STATUS, 8'h01);
    val <= v;
    go  <= 1'b1;
    @(posedge clk);
    go  <= 1'b0;
  endtask : kick

  task wait_done;
    int n;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (done !== 1'b1 && n < 400);
    @(posedge clk);
    if (done !== 1'b1) begin
      n_mismatch++;
      end_of_test();
    end
  endtask : wait_done

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task t_reset;
    for (int a = 0; a < 4; a++) rdchk(a[1:0], 8'h00);
    chk({27'h0, refsel, chan}, 32'h0);
  endtask : t_reset

  task t_ref;
    for (int r = 0; r < 4; r++) begin
      bus(1'b1, ADDR_SEL, {r[1:0], 6'h00});
      chk({30'h0, refsel}, r);
      chk({31'h0, iref}, {31'h0, r == 3});
      rdchk(ADDR_SEL, {r[1:0], 6'h00});
    end
  endtask : t_ref

  task t_single;
    logic [11:0] vin [3] = '{12'h000, 12'h3FF, 12'h7FF};
    logic [9:0]  exp [3] = '{10'h000, 10'h3FF, 10'h3FF};
    bus(1'b1, ADDR_SEL, 8'h40);
    for (int i = 0; i < 3; i++) begin
      kick(vin[i]);
      wait_done();
      rdchk(ADDR_STATUS, 8'h01);
      rdchk(ADDR_RES_LOW, exp[i][7:0]);
      rdchk(ADDR_RES_HIGH, {6'h00, exp[i][9:8]});
    end
    bus(1'b1, ADDR_RES_LOW, 8'hAA);
    rdchk(ADDR_RES_LOW, 8'hFF);
  endtask : t_single

  task t_diff;
    logic [11:0] vin [4] = '{12'h258, 12'hFFF, 12'hDA8, 12'hE70};
    logic [9:0]  exp [4] = '{10'h1FF, 10'h3FF, 10'h200, 10'h270};
    bus(1'b1, ADDR_SEL, 8'hE8);
    for (int i = 0; i < 4; i++) begin
      kick(vin[i]);
      wait_done();
      rdchk(ADDR_RES_HIGH, exp[i][9:2]);
      chk({31'h0, q[7]}, {31'h0, vin[i][11]});
      rdchk(ADDR_RES_LOW, {exp[i][1:0], 6'h00});
    end
    bus(1'b1, ADDR_SEL, 8'hC8);
    rdchk(ADDR_RES_LOW, 8'h70);
    rdchk(ADDR_RES_HIGH, 8'h02);
  endtask : t_diff

  task t_defer;
    bus(1'b1, ADDR_SEL, 8'h61);
    rdchk(ADDR_RES_HIGH, 8'h9C);
    kick(12'h155);
    repeat (3) @(posedge clk);
    chk({31'h0, busy}, 32'h1);
    bus(1'b1, ADDR_SEL, 8'hC5);
    chk({27'h0, refsel, chan}, {27'h0, 2'h1, 5'h01});
    rdchk(ADDR_RES_LOW, 8'h70);
    wait_done();
    chk({26'h0, iref, refsel, chan}, {26'h0, 1'b1, 2'h3, 5'h05});
    rdchk(ADDR_RES_LOW, 8'h55);
    rdchk(ADDR_RES_HIGH, 8'h01);
    bus(1'b1, ADDR_STATUS, 8'h01);
    rdchk(ADDR_STATUS, 8'h00);
  endtask : t_defer

  initial begin
    rst   = 1'b1;
    rd    = 1'b0;
    wr    = 1'b0;
    go    = 1'b0;
    addr  = 2'h0;
    wdata = 32'h0;
    val   = 12'h000;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_ref();
    t_single();
    t_diff();
    t_defer();
    end_of_test();
  end
endmodule : adc_select_and_result_format_test
